// ---- pkg/lic_pkg.sv ----
// Shared constants for the level interrupt controller.
package lic_pkg;
  // External pin count and edge mode encoding.
  localparam int EXT_PINS = 8;
  localparam int EDGE_W = 2;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Interrupt level field width; level 0 means the source never requests.
  localparam int LVL_W = 2;
  localparam int NUM_LEVELS = (1 << LVL_W) - 1;
  localparam logic [NUM_LEVELS-1:0] CIL_RESET = 3'h0;
  // The sampling tick is the low-speed clock divided by this figure.
  localparam int LS_DIV = 2;
  // Noise filter: the pin must hold its level for this long before it passes.
  localparam int CLK_PERIOD_NS = 25;
  localparam int FILTER_NS = 75;
  localparam int FILTER_CYC = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- rtl/lic_pin_filter.sv ----
// Noise filter and tick sampler for one external interrupt pin.
module lic_pin_filter
  import lic_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  input wire logic tick,
  input wire logic filterEn,
  input wire logic sampleEn,
  output logic sigOut,
  output logic trigOut
);
  localparam int CNT_W = $clog2(FILTER_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(FILTER_CYC);

  typedef struct packed {
    logic filt;
    logic [CNT_W-1:0] cnt;
    logic smpA;
    logic smpOut;
    logic out;
  } lpf_state_s;

  lpf_state_s st;
  lpf_state_s next_st;
  logic preSample;

  // The filter only follows the pin after it has stayed put for the full count.
  always_comb begin
    next_st = st;
    preSample = filterEn ? st.filt : pin;
    if (pin == st.filt) begin
      next_st.cnt = '0;
    end else if (st.cnt == CNT_MAX - CNT_W'(1)) begin
      next_st.filt = pin;
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
    // Two tick samples must agree before the sampled level moves.
    if (tick) begin
      next_st.smpA = preSample;
      if (preSample == st.smpA) begin
        next_st.smpOut = preSample;
      end
    end
    next_st.out = sampleEn ? st.smpOut : preSample;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sigOut = st.out;
  // The timer trigger copy ignores both enables and is always filtered.
  assign trigOut = st.filt;
endmodule

// ---- rtl/level_interrupt_controller.sv ----
// Level nesting interrupt controller with external pin edge detection.

// Overview of operation
// - Any write to the level register clears only its highest set bit.
// - Request the core when a pending source level exceeds the current level.
// - Among several qualifying sources, present only the highest priority one.
// - Hold requests from transfer cycle until the first handler instruction ran.
// - Hold requests after a segment prefix until the following instruction ran.
// - Each of eight pins raises its own request on its selected edge.
// - Per pin edge mode: rising, falling or both edges.
// - Pins optionally filtered and/or twice sampled on low-speed clock over two.
// - The timer trigger copy is always filtered and never sampled.
module level_interrupt_controller
  import lic_pkg::*;
#(
  parameter int NUM_SRC = 16
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [NUM_SRC-1:0] srcPending,
  input wire logic [NUM_SRC*LVL_W-1:0] srcLevel,
  input wire logic curLevelWrite,
  input wire logic irqAccept,
  input wire logic shiftCycle,
  input wire logic firstInstrDone,
  input wire logic prefixExec,
  input wire logic nextInstrDone,
  input wire logic [EXT_PINS-1:0] extPin,
  input wire logic [EXT_PINS*EDGE_W-1:0] edgeSelect,
  input wire logic [EXT_PINS-1:0] filterEnable,
  input wire logic [EXT_PINS-1:0] sampleEnable,
  input wire logic lowSpeedClk,
  output logic irqRequest,
  output logic [$clog2(NUM_SRC)-1:0] irqVector,
  output logic [LVL_W-1:0] irqLevel,
  output logic [NUM_LEVELS-1:0] curLevel,
  output logic [EXT_PINS-1:0] extIntRequest,
  output logic [EXT_PINS-1:0] timerTrigger
);
  localparam int IDX_W = $clog2(NUM_SRC);

  // Elaboration refuses a source count that the vector and level logic cannot serve.
  if (NUM_SRC < 2 || NUM_SRC > 256) begin : g_bad_num_src
    $error("NUM_SRC must lie between 2 and 256.");
  end

  typedef struct packed {
    logic [NUM_LEVELS-1:0] current_level_register;
    logic holdShift;
    logic holdPrefix;
    logic req;
    logic [IDX_W-1:0] vec;
    logic [LVL_W-1:0] lvl;
    logic [NUM_SRC-1:0] cand;
    logic [EXT_PINS-1:0] pinS1;
    logic [EXT_PINS-1:0] pinS2;
    logic [EXT_PINS-1:0] prevSig;
    logic [EXT_PINS-1:0] extReq;
    logic [EXT_PINS-1:0] trig;
    logic lsS1;
    logic lsS2;
    logic lsPrev;
    logic lsDiv;
    logic tick;
  } lic_state_s;

  lic_state_s st;
  lic_state_s next_st;
  logic [EXT_PINS-1:0] filtSig;
  logic [EXT_PINS-1:0] filtTrig;
  logic [NUM_SRC-1:0] cand;
  logic anyCand;
  logic [IDX_W-1:0] winIdx;
  logic [LVL_W-1:0] winLvl;
  logic holdNow;

  // One-hot mask of the highest set bit of the level register.
  function automatic logic [NUM_LEVELS-1:0] msbMask(input logic [NUM_LEVELS-1:0] v);
    logic [NUM_LEVELS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_LEVELS; i++) begin
      if (v[i]) begin
        m = '0;
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // Current level as a number: highest set bit position plus one, zero when idle.
  function automatic logic [LVL_W-1:0] msbLevel(input logic [NUM_LEVELS-1:0] v);
    logic [LVL_W-1:0] l;
    l = '0;
    for (int i = 0; i < NUM_LEVELS; i++) begin
      if (v[i]) begin
        l = LVL_W'(i + 1);
      end
    end
    return l;
  endfunction

  // Per pin filtering; the sampler's tick comes from the divided low-speed clock.
  for (genvar p = 0; p < EXT_PINS; p++) begin : g_pin
    lic_pin_filter u_filter (
      .clk(clk),
      .resetn(resetn),
      .pin(st.pinS2[p]),
      .tick(st.tick),
      .filterEn(filterEnable[p]),
      .sampleEn(sampleEnable[p]),
      .sigOut(filtSig[p]),
      .trigOut(filtTrig[p])
    );
  end

  // Arbitration: a source qualifies only above the current level; lower index wins.
  always_comb begin
    cand = '0;
    anyCand = 1'b0;
    winIdx = '0;
    winLvl = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (srcPending[i] && srcLevel[i*LVL_W +: LVL_W] > msbLevel(st.current_level_register)) begin
        cand[i] = 1'b1;
        anyCand = 1'b1;
        winIdx = IDX_W'(i);
        winLvl = srcLevel[i*LVL_W +: LVL_W];
      end
    end
  end

  // Hold windows close in the same cycle their ending instruction reports done,
  // so a waiting request is presented on the very next edge.
  always_comb begin
    holdNow = (st.holdShift & ~firstInstrDone) | shiftCycle
            | (st.holdPrefix & ~nextInstrDone) | prefixExec;
  end

  // Main next-state process.
  always_comb begin
    next_st = st;
    next_st.cand = cand;
    if (shiftCycle) begin
      next_st.holdShift = 1'b1;
    end else if (firstInstrDone) begin
      next_st.holdShift = 1'b0;
    end
    if (prefixExec) begin
      next_st.holdPrefix = 1'b1;
    end else if (nextInstrDone) begin
      next_st.holdPrefix = 1'b0;
    end
    next_st.req = anyCand & ~holdNow & ~irqAccept;
    next_st.vec = winIdx;
    next_st.lvl = winLvl;
    // Clear first, then set, so an acceptance in the same cycle is never lost.
    if (curLevelWrite) begin
      next_st.current_level_register = st.current_level_register & ~msbMask(st.current_level_register);
    end
    if (irqAccept && st.req && st.lvl != '0) begin
      next_st.current_level_register[st.lvl - LVL_W'(1)] = 1'b1;
    end
    // Two-stage synchronisers for the asynchronous pins.
    next_st.pinS1 = extPin;
    next_st.pinS2 = st.pinS1;
    next_st.lsS1 = lowSpeedClk;
    next_st.lsS2 = st.lsS1;
    next_st.lsPrev = st.lsS2;
    // Every second low-speed rising edge yields a one-cycle tick.
    next_st.tick = 1'b0;
    if (st.lsS2 && !st.lsPrev) begin
      next_st.lsDiv = ~st.lsDiv;
      next_st.tick = st.lsDiv;
    end
    // Edge detection per pin on the filtered/sampled signal.
    next_st.prevSig = filtSig;
    for (int p = 0; p < EXT_PINS; p++) begin
      case (edgeSelect[p*EDGE_W +: EDGE_W])
        EDGE_RISE: next_st.extReq[p] = filtSig[p] & ~st.prevSig[p];
        EDGE_FALL: next_st.extReq[p] = ~filtSig[p] & st.prevSig[p];
        EDGE_BOTH: next_st.extReq[p] = filtSig[p] ^ st.prevSig[p];
        default: next_st.extReq[p] = 1'b0;
      endcase
    end
    next_st.trig = filtTrig;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign irqRequest = st.req;
  assign irqVector = st.vec;
  assign irqLevel = st.lvl;
  assign curLevel = st.current_level_register;
  assign extIntRequest = st.extReq;
  assign timerTrigger = st.trig;

  // Checks on the level register, arbitration, hold windows, pin edges and the sampling tick.
  sequence s_shift_window;
    shiftCycle ##1 !firstInstrDone;
  endsequence

  sequence s_prefix_window;
    prefixExec ##1 !nextInstrDone;
  endsequence

  a_cil_clear_msb: assert property (@(posedge clk) disable iff (!resetn)
    curLevelWrite && !irqAccept |=> curLevel == ($past(curLevel) & ~msbMask($past(curLevel))))
    else $error("Level write did not clear exactly the highest bit.");

  a_cil_accept_set: assert property (@(posedge clk) disable iff (!resetn)
    irqAccept && irqRequest |=> curLevel[$past(irqLevel) - LVL_W'(1)])
    else $error("Accepted level bit not set.");

  a_req_raise: assert property (@(posedge clk) disable iff (!resetn)
    anyCand && !holdNow && !irqAccept |=> irqRequest)
    else $error("Qualifying source was not requested.");

  a_req_above_level: assert property (@(posedge clk) disable iff (!resetn)
    irqRequest |-> irqLevel > msbLevel($past(curLevel)) && $past(anyCand))
    else $error("Request without a source above the current level.");

  a_prio_winner: assert property (@(posedge clk) disable iff (!resetn)
    irqRequest |-> st.cand[irqVector] && ((st.cand & ((NUM_SRC'(1) << irqVector) - 1)) == '0))
    else $error("Presented source is not the highest priority candidate.");

  a_hold_shift: assert property (@(posedge clk) disable iff (!resetn)
    s_shift_window |-> !irqRequest ##1 !irqRequest)
    else $error("Request inside the transfer hold window.");

  a_hold_release: assert property (@(posedge clk) disable iff (!resetn)
    st.holdShift && firstInstrDone && !shiftCycle && !st.holdPrefix && !prefixExec && anyCand
    && !irqAccept
    |=> irqRequest)
    else $error("Held request not taken right after the first instruction.");

  a_hold_prefix: assert property (@(posedge clk) disable iff (!resetn)
    s_prefix_window |-> !irqRequest ##1 !irqRequest)
    else $error("Request inside the prefix hold window.");

  a_ext_edge: assert property (@(posedge clk) disable iff (!resetn)
    edgeSelect[3:2] == EDGE_RISE && $rose(filtSig[1]) |=> extIntRequest[1] ##1 !extIntRequest[1]
      || $rose(filtSig[1]))
    else $error("Rising edge on pin one gave no single request pulse.");

  a_tick_rate: assert property (@(posedge clk) disable iff (!resetn)
    st.tick |-> !$past(st.tick) && $past(st.lsS2) && !$past(st.lsPrev))
    else $error("Sampling tick not aligned to a low-speed edge.");
endmodule

// ---- verif/lic_core_model.sv ----
// Core-side model that takes presented requests, drops their flags and releases levels.
module lic_core_model
  import lic_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic takeEn,
  input wire logic releaseReq,
  input wire logic [15:0] raiseMask,
  input wire logic irqRequest,
  input wire logic [3:0] irqVector,
  output logic irqAccept,
  output logic curLevelWrite,
  output logic [15:0] srcPending
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;

  // No non-maskable source reaches this block; a core would still take one inside
  // a maskable handler whatever its enable state, so the model never gates on it.

  // A request is taken once per presentation; the accept pulse blocks a double take.
  assign take = takeEn && irqRequest && !irqAccept;

  // Handler context is treated as saved on entry and restored on exit.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqAccept <= 1'b0;
      curLevelWrite <= 1'b0;
      srcPending <= 16'h0000;
    end else begin
      irqAccept <= take;
      curLevelWrite <= releaseReq; // The bench drops takeEn before a release.
      srcPending <= (srcPending | raiseMask) & ~(take ? (16'h0001 << irqVector) : 16'h0000);
    end
  end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the level interrupt controller.
module tb_top
  import lic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, takeEn, releaseReq, irqAccept, curLevelWrite, irqRequest;
  logic lowSpeedClk = 1'b0;
  logic shiftCycle, firstInstrDone, prefixExec, nextInstrDone;
  logic [15:0] raiseMask, srcPending;
  logic [3:0] irqVector;
  logic [1:0] irqLevel;
  logic [2:0] curLevel;
  logic [7:0] extPin, extIntRequest, timerTrigger;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int cnt[8] = '{default: 0};
  int base[8];
  int upExp[8] = '{0, 1, 0, 1, 1, 1, 1, 1};
  int downExp[8] = '{0, 0, 1, 1, 0, 0, 0, 1};

  // Sources 2 and 5 sit at level 2, 9 at level 3, 12 at level 1.
  // Pin modes 0..7: off, rise, fall, both, rise, rise, rise, both.
  level_interrupt_controller i_level_interrupt_controller (
    .clk(clk),
    .resetn(resetn),
    .srcPending(srcPending),
    .srcLevel(32'h010c0820),
    .curLevelWrite(curLevelWrite),
    .irqAccept(irqAccept),
    .shiftCycle(shiftCycle),
    .firstInstrDone(firstInstrDone),
    .prefixExec(prefixExec),
    .nextInstrDone(nextInstrDone),
    .extPin(extPin),
    .edgeSelect(16'hd5e4),
    .filterEnable(8'h90),
    .sampleEnable(8'h40),
    .lowSpeedClk(lowSpeedClk),
    .irqRequest(irqRequest),
    .irqVector(irqVector),
    .irqLevel(irqLevel),
    .curLevel(curLevel),
    .extIntRequest(extIntRequest),
    .timerTrigger(timerTrigger)
  );

  lic_core_model i_lic_core_model (
    .clk(clk),
    .resetn(resetn),
    .takeEn(takeEn),
    .releaseReq(releaseReq),
    .raiseMask(raiseMask),
    .irqRequest(irqRequest),
    .irqVector(irqVector),
    .irqAccept(irqAccept),
    .curLevelWrite(curLevelWrite),
    .srcPending(srcPending)
  );

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Slow clock, pulse counting and the hang limit, which is far above the planned run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 7) lowSpeedClk <= ~lowSpeedClk;
    for (int i = 0; i < 8; i++) if (extIntRequest[i] === 1'b1) cnt[i]++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_cnt(int i, int exp);
    n_tests++;
    if (cnt[i] - base[i] != exp) begin
      n_fail++;
      $display("BAD pulses pin %0d expected %0d seen %0d", i, exp, cnt[i] - base[i]);
    end
  endtask

  // Let the core take the next request and check what was presented and recorded.
  task automatic take(logic [3:0] vec, logic [1:0] lvl, logic [2:0] cur);
    int k;
    k = 0;
    @(posedge clk) takeEn <= 1'b1;
    while (irqAccept !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk("irqVector", 16'(vec), 16'(irqVector));
    chk("irqLevel", 16'(lvl), 16'(irqLevel));
    @(posedge clk) takeEn <= 1'b0;
    @(negedge clk) chk("curLevel", 16'(cur), 16'(curLevel));
  endtask

  // One software write to the level register, checked once it has landed.
  task automatic release_level(logic [2:0] cur);
    @(posedge clk) releaseReq <= 1'b1;
    @(posedge clk) releaseReq <= 1'b0;
    @(posedge clk);
    @(negedge clk) chk("curLevel", 16'(cur), 16'(curLevel));
  endtask

  task automatic quiet(int n);
    repeat (n) @(negedge clk) chk("irqRequest", 16'h0000, 16'(irqRequest));
  endtask

  task automatic pins_to(logic [7:0] v, int e[8]);
    for (int i = 0; i < 8; i++) base[i] = cnt[i];
    @(posedge clk) extPin <= v;
    repeat (10) @(posedge clk);
    @(negedge clk) chk("timerTrigger", 16'(v), 16'(timerTrigger));
    repeat (120) @(posedge clk);
    for (int i = 0; i < 8; i++) chk_cnt(i, e[i]);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence: nesting, hold windows, then the external pins.
  initial begin
    {resetn, takeEn, releaseReq, shiftCycle, firstInstrDone} = '0;
    {prefixExec, nextInstrDone, raiseMask, extPin} = '0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk) chk("curLevel", 16'h0000, 16'(curLevel));
    @(posedge clk) raiseMask <= 16'h0224;
    @(posedge clk) raiseMask <= 16'h0000;
    take(4'h2, 2'h2, 3'h2);
    take(4'h9, 2'h3, 3'h6);
    quiet(6);
    release_level(3'h2);
    quiet(6);
    release_level(3'h0);
    take(4'h5, 2'h2, 3'h2);
    release_level(3'h0);
    for (int w = 0; w < 2; w++) begin
      @(posedge clk) raiseMask <= 16'h1000;
      shiftCycle <= (w == 0);
      prefixExec <= (w == 1);
      @(posedge clk) {raiseMask, shiftCycle, prefixExec} <= '0;
      quiet(5);
      @(posedge clk) firstInstrDone <= (w == 0);
      nextInstrDone <= (w == 1);
      @(posedge clk) {firstInstrDone, nextInstrDone} <= '0;
      @(negedge clk) chk("irqRequest", 16'h0001, 16'(irqRequest));
      take(4'hc, 2'h1, 3'h1);
      release_level(3'h0);
    end
    for (int i = 0; i < 8; i++) base[i] = cnt[i];
    @(posedge clk) extPin <= 8'h70;
    repeat (2) @(posedge clk);
    extPin <= 8'h00;
    // A two-cycle glitch must never reach the always-filtered trigger copy.
    repeat (4) @(negedge clk) chk("timerTrigger", 16'h0000, 16'(timerTrigger));
    repeat (80) @(posedge clk);
    chk_cnt(4, 0);
    chk_cnt(5, 1);
    chk_cnt(6, 0);
    pins_to(8'hff, upExp);
    pins_to(8'h00, downExp);
    tally_and_finish();
  end
endmodule
